/* core/psi5is_seq.sv */
// Initialization phase 1 and phase 2 sequencer
module psi5is_seq
   import psi5is_pkg::*;
#(
   parameter int SETTLE_CYCLES = psi5is_pkg::SETTLE_CYC,
   parameter int OC1_CYCLES    = psi5is_pkg::OC1_CYC,
   parameter int PME_CYCLES    = psi5is_pkg::PME_CYC,
   parameter int OC2_CYCLES    = psi5is_pkg::OC2_CYC,
   parameter int FRAME_CYCLES  = psi5is_pkg::ASYNC_FRAME_CYC,
   parameter int ENTRY_PULSES  = psi5is_pkg::PME_PULSES
) (
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   input  wire psi5is_pkg::psi5is_cfg_s   cfg,
   input  wire logic                      user_lock,
   input  wire logic                      sync_pulse,
   input  wire logic                      nib_wr_en,
   input  wire logic [psi5is_pkg::NIB_AW-1:0] nib_wr_addr,
   input  wire logic [3:0]                nib_wr_data,
   output psi5is_pkg::psi5is_tx_s         tx,
   output logic                           self_check_en,
   output logic                           offset_cancel_one,
   output logic                           offset_cancel_two,
   output logic                           prog_mode,
   output logic                           second_phase_start,
   output logic                           second_phase_done,
   output logic                           normal_mode
);
   import psi5is_pkg::*;

   // ****************************************************************
   // State and counters
   // ****************************************************************
   psi5is_state_e state_q, state_d;
   psi5is_cfg_s   cfg_q, cfg_d;
   psi5is_tx_s    tx_q, tx_d;
   logic [23:0]   tmr_q, tmr_d;
   logic [3:0]    pulse_q, pulse_d;
   logic          hit_q, hit_d;
   logic [5:0]    field_q, field_d;
   logic          half_q, half_d;
   logic [3:0]    rep_q, rep_d;
   logic          slot_q, slot_d;     // 0: ID frame, 1: data frame
   logic [9:0]    txcnt_q, txcnt_d;
   logic          done_q, done_d;
   logic [3:0]    nib;
   logic [1:0]    nib2;
   logic          trig, last_rep, last_nib;
   logic [5:0]    nfields;
   logic [3:0]    k_cnt;

   // Nibble of the current field, read one cycle after the field moves
   psi5is_nib_mem #(
      .DEPTH (NIB_DEPTH),
      .AW    (NIB_AW)
   ) u_mem (
      .sys_clk (sys_clk),
      .wr_en   (nib_wr_en),
      .wr_addr (nib_wr_addr),
      .wr_data (nib_wr_data),
      .rd_addr (field_q[NIB_AW-1:0]),
      .rd_data (nib)
   );

   // Mode-dependent sizing from the held configuration
   always_comb begin
      nfields  = cfg_q.data_len_10 ? FIELDS_10 : FIELDS_8;
      k_cnt    = cfg_q.sync_mode ? K_SYNC : K_ASYNC;
      nib2     = half_q ? nib[1:0] : nib[3:2];
      last_rep = slot_q && (rep_q == k_cnt - 4'd1);
      last_nib = cfg_q.data_len_10 || half_q;
      // Sync mode frames follow the receiver; async uses own period
      trig     = cfg_q.sync_mode ? sync_pulse : (tmr_q == 24'd0);
   end

   // ****************************************************************
   // Sequencer next state
   // ****************************************************************
   always_comb begin
      state_d  = state_q;
      cfg_d    = cfg_q;
      tmr_d    = (tmr_q == 24'd0) ? tmr_q : tmr_q - 24'd1;
      pulse_d  = pulse_q;
      hit_d    = hit_q;
      field_d  = field_q;
      half_d   = half_q;
      rep_d    = rep_q;
      slot_d   = slot_q;
      txcnt_d  = txcnt_q;
      done_d   = 1'b0;
      tx_d     = '0;                   // No frames outside phase 2
      case (state_q)
         ST_SETTLE: begin
            if (tmr_q == 24'd0) begin
               state_d = ST_OC1;
               tmr_d   = 24'(OC1_CYCLES - 1);
            end
         end
         ST_OC1: begin
            if (tmr_q == 24'd0) begin
               state_d = ST_PME;
               tmr_d   = 24'(PME_CYCLES - 1);
               pulse_d = 4'd0;
            end
         end
         ST_PME: begin
            // Count pulses only inside the window; lock vetoes entry
            if (sync_pulse && pulse_q != 4'hf) begin
               pulse_d = pulse_q + 4'd1;
            end
            if (sync_pulse && !user_lock && pulse_q == 4'(ENTRY_PULSES - 1)) begin
               hit_d = 1'b1;
            end
            if (tmr_q == 24'd0) begin
               state_d = ST_OC2;
               tmr_d   = 24'(OC2_CYCLES - 1);
            end
         end
         ST_OC2: begin
            if (tmr_q == 24'd0) begin
               if (hit_q) begin
                  state_d = ST_PROG;
               end else begin
                  state_d = ST_PH2;
                  cfg_d   = cfg;        // Latched once
                  tmr_d   = 24'(FRAME_CYCLES - 1);
                  field_d = 6'd0;
                  half_d  = 1'b0;
                  rep_d   = 4'd0;
                  slot_d  = 1'b0;
                  txcnt_d = 10'd0;
               end
            end
         end
         ST_PH2: begin
            if (!cfg_q.sync_mode && tmr_q == 24'd0) begin
               tmr_d = 24'(FRAME_CYCLES - 1);
            end
            if (trig) begin
               tx_d.valid = 1'b1;
               txcnt_d    = txcnt_q + 10'd1;
               // ID frame first, then its data frame
               if (cfg_q.data_len_10) begin
                  tx_d.code = slot_q ? DATA_BASE_10 - {6'd0, nib}
                                     : ID_BASE_10 - {6'd0, field_q[3:0]};
               end else begin
                  tx_d.code = {2'd0, slot_q ? DATA_BASE_8 - {6'd0, nib2}
                                            : ID_BASE_8 - {6'd0, field_q[0], half_q}};
               end
               slot_d = ~slot_q;
               if (slot_q) begin
                  rep_d = rep_q + 4'd1;
               end
               // Pair repeats k times before the next nibble
               if (last_rep) begin
                  rep_d  = 4'd0;
                  half_d = cfg_q.data_len_10 ? 1'b0 : ~half_q;
                  if (last_nib) begin
                     field_d = field_q + 6'd1;
                     if (field_q == nfields - 6'd1) begin
                        state_d = ST_DONE;
                        done_d  = 1'b1;
                     end
                  end
               end
            end
         end
         ST_PROG: begin
            state_d = ST_PROG;          // Left only by the synchronous reset
         end
         ST_DONE: begin
            state_d = ST_DONE;
         end
         default: begin
            state_d = ST_SETTLE;
         end
      endcase
   end

   // Register stage only; the synchronous reset restarts phase 1
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_SETTLE;
         cfg_q   <= '0;
         tx_q    <= '0;
         tmr_q   <= 24'(SETTLE_CYCLES - 1);
         pulse_q <= 4'd0;
         hit_q   <= 1'b0;
         field_q <= 6'd0;
         half_q  <= 1'b0;
         rep_q   <= 4'd0;
         slot_q  <= 1'b0;
         txcnt_q <= 10'd0;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cfg_q   <= cfg_d;
         tx_q    <= tx_d;
         tmr_q   <= tmr_d;
         pulse_q <= pulse_d;
         hit_q   <= hit_d;
         field_q <= field_d;
         half_q  <= half_d;
         rep_q   <= rep_d;
         slot_q  <= slot_d;
         txcnt_q <= txcnt_d;
         done_q  <= done_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Self checks run from reset through phase 2
   assign self_check_en      = (state_q != ST_PROG) && (state_q != ST_DONE);
   assign offset_cancel_one  = (state_q == ST_OC1);
   assign offset_cancel_two  = (state_q == ST_OC2);
   assign prog_mode          = (state_q == ST_PROG);
   assign second_phase_start = (state_q == ST_PH2);
   assign second_phase_done  = done_q;
   assign normal_mode        = (state_q == ST_DONE);
   assign tx                 = tx_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_silent_phase_one: assert property (tx.valid |-> $past(state_q) == ST_PH2)
      else $error("frame sent outside phase 2");
   a_order_oc_one: assert property ($rose(state_q == ST_OC1) |-> $past(state_q) == ST_SETTLE)
      else $error("offset stage one not after settling");
   a_order_oc_two: assert property ($rose(state_q == ST_OC2) |-> $past(state_q) == ST_PME)
      else $error("offset stage two not after watch window");
   a_prog_entry: assert property ((state_q == ST_OC2 && tmr_q == 24'd0 && hit_q)
                                  |=> prog_mode)
      else $error("entry pattern did not enter programming");
   a_lock_veto: assert property ((state_q == ST_PME && user_lock) |=> $stable(hit_q))
      else $error("locked device armed programming");
   a_go_phase_two: assert property ((state_q == ST_OC2 && tmr_q == 24'd0 && !hit_q)
                                    |=> state_q == ST_PH2)
      else $error("phase 2 not entered");
   a_cfg_held: assert property ((state_q == ST_PH2 && $past(state_q) == ST_PH2)
                                |-> $stable(cfg_q))
      else $error("configuration changed in phase 2");
   a_sync_trig: assert property ((state_q == ST_PH2 && cfg_q.sync_mode && sync_pulse)
                                 |=> tx.valid)
      else $error("sync pulse produced no frame");
   a_code_range10: assert property ((tx.valid && cfg_q.data_len_10)
                                    |-> tx.code inside {[10'h200:10'h21f]})
      else $error("10-bit code outside reserved range");
   a_code_range8: assert property ((tx.valid && !cfg_q.data_len_10)
                                   |-> tx.code inside {[10'h080:10'h087]})
      else $error("8-bit code outside reserved range");
   a_total_count: assert property (done_q |-> txcnt_q ==
                     10'({7'd0, cfg_q.data_len_10 ? TRANS_10 : TRANS_8} * {6'd0, k_cnt}
                         * {4'd0, nfields}))
      else $error("phase 2 transmission count wrong");
   a_done_stays: assert property (normal_mode |=> normal_mode && !tx.valid)
      else $error("left normal operation");

   c_prog: cover property (state_q == ST_OC2 ##1 prog_mode);
   c_async10: cover property (done_q && cfg_q.data_len_10 && !cfg_q.sync_mode);
   c_sync10: cover property (done_q && cfg_q.data_len_10 && cfg_q.sync_mode);
   c_eight: cover property (done_q && !cfg_q.data_len_10);
endmodule

/* include/psi5is_pkg.sv */
// Shared constants and types for the initialization phase sequencer
package psi5is_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_MHZ          = 20;     // sys_clk rate
   localparam int T_SETTLE_US      = 1000;   // Analog settling delay
   localparam int OFFSET_CANCEL_STAGE_ONE_TIME_US         = 2000;   // offset_cancel_stage_one_time
   localparam int PROG_ENTRY_WATCH_WINDOW_US         = 5000;   // prog_entry_watch_window
   localparam int OFFSET_CANCEL_STAGE_TWO_TIME_US         = 2000;   // offset_cancel_stage_two_time
   localparam int T_ASYNC_FRAME_US = 228;    // Asynchronous frame period
   localparam int SETTLE_CYC       = T_SETTLE_US * CLK_MHZ;
   localparam int OC1_CYC          = OFFSET_CANCEL_STAGE_ONE_TIME_US * CLK_MHZ;
   localparam int PME_CYC          = PROG_ENTRY_WATCH_WINDOW_US * CLK_MHZ;
   localparam int OC2_CYC          = OFFSET_CANCEL_STAGE_TWO_TIME_US * CLK_MHZ;
   localparam int ASYNC_FRAME_CYC  = T_ASYNC_FRAME_US * CLK_MHZ;
   localparam int PME_PULSES       = 4;      // Sync pulses forming the entry pattern

   // ****************************************************************
   // Phase 2 framing
   // ****************************************************************
   localparam logic [5:0] FIELDS_10   = 6'd32;
   localparam logic [5:0] FIELDS_8    = 6'd9;
   localparam logic [2:0] TRANS_10    = 3'd2;   // transmissions_per_field
   localparam logic [2:0] TRANS_8     = 3'd4;
   localparam logic [3:0] K_ASYNC     = 4'd8;
   localparam logic [3:0] K_SYNC      = 4'd4;
   localparam logic [9:0] DATA_BASE_10 = 10'h21f;  // -481
   localparam logic [9:0] ID_BASE_10   = 10'h20f;  // -497
   localparam logic [7:0] DATA_BASE_8  = 8'h87;    // -121
   localparam logic [7:0] ID_BASE_8    = 8'h83;    // -125
   localparam int         NIB_DEPTH    = 32;
   localparam int         NIB_AW       = 5;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [6:0] {
      ST_SETTLE = 7'h01,
      ST_OC1    = 7'h02,
      ST_PME    = 7'h04,
      ST_OC2    = 7'h08,
      ST_PH2    = 7'h10,
      ST_PROG   = 7'h20,
      ST_DONE   = 7'h40
   } psi5is_state_e;

   typedef struct packed {
      logic data_len_10;   // 1: 10-bit data, 0: 8-bit data
      logic sync_mode;     // 1: synchronous, 0: asynchronous
   } psi5is_cfg_s;

   typedef struct packed {
      logic       valid;   // One-cycle frame request
      logic [9:0] code;    // Reserved code, 8-bit codes in bits 7:0
   } psi5is_tx_s;

endpackage

/* core/psi5is_nib_mem.sv */
// Field nibble store with registered read data
module psi5is_nib_mem #(
   parameter int DEPTH = psi5is_pkg::NIB_DEPTH,
   parameter int AW    = psi5is_pkg::NIB_AW
) (
   input  wire logic          sys_clk,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [3:0]    wr_data,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [3:0]    rd_data
);
   logic [3:0] mem_q [DEPTH];

   // Plain array, no reset, so it maps onto a small RAM
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
      rd_data <= mem_q[rd_addr];
   end
endmodule

/* sim/psi5is_rx_model.sv */
// Receiver model: source of sync pulses for the sequencer
module psi5is_rx_model
   import psi5is_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       run,
   input  wire logic [7:0] gap,
   output logic            sync_pulse
);
   timeunit 1ns;
   timeprecision 1ns;

   logic       run_q;
   logic [7:0] cnt;

   initial begin
      run_q = 1'b0;
      cnt = 8'h00;
      sync_pulse = 1'b0;
   end

   // Run request taken at the rising edge, so it never races the bench
   always @(posedge sys_clk) begin
      run_q <= run;
   end

   // One-cycle pulse every gap cycles; a gap of one holds the pulse high every cycle
   always @(negedge sys_clk) begin
      if (run_q) begin
         sync_pulse <= (cnt == 8'h00);
         cnt <= (cnt == 8'h00) ? gap - 8'h01 : cnt - 8'h01;
      end else begin
         sync_pulse <= 1'b0;
         cnt <= 8'h00;
      end
   end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the initialization phase sequencer
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import psi5is_pkg::*;

   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   localparam int FRAME = 8;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   psi5is_cfg_s cfg = 2'b00;
   logic        user_lock = 1'b0;
   logic        sync_pulse;
   logic        nib_wr_en = 1'b0;
   logic [4:0]  nib_wr_addr = 5'h00;
   logic [3:0]  nib_wr_data = 4'h0;
   psi5is_tx_s  tx;
   logic        self_check_en, offset_cancel_one, offset_cancel_two, prog_mode;
   logic        second_phase_start, second_phase_done, normal_mode;
   logic        run = 1'b0;
   logic [7:0]  gap = 8'h04;
   logic [9:0]  got[$];
   int          fail_count = 0, checks = 0, cyc = 0, stamp = 0, gap_exp = 0, done_seen = 0;

   psi5is_seq #(.SETTLE_CYCLES(40), .OC1_CYCLES(20), .PME_CYCLES(200), .OC2_CYCLES(20),
      .FRAME_CYCLES(FRAME), .ENTRY_PULSES(4)) uut (.sys_clk(sys_clk), .rst(rst), .cfg(cfg),
      .user_lock(user_lock), .sync_pulse(sync_pulse), .nib_wr_en(nib_wr_en),
      .nib_wr_addr(nib_wr_addr), .nib_wr_data(nib_wr_data), .tx(tx),
      .self_check_en(self_check_en), .offset_cancel_one(offset_cancel_one),
      .offset_cancel_two(offset_cancel_two), .prog_mode(prog_mode),
      .second_phase_start(second_phase_start), .second_phase_done(second_phase_done),
      .normal_mode(normal_mode));
   psi5is_rx_model rx (.sys_clk(sys_clk), .run(run), .gap(gap), .sync_pulse(sync_pulse));

   // 20 MHz clock
   always #25 sys_clk = ~sys_clk;

   // ****************************************************************
   // Checking helpers
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   function automatic logic [3:0] nibv(input int f);
      return 4'(f * 7 + 3);
   endfunction

   // Frame sink and watchdog, sampled where outputs have settled
   always @(negedge sys_clk) begin
      cyc++;
      if (cyc > 40000) begin
         fail_count++;
         summarize();
      end
      if (tx.valid === 1'b1) begin
         if (got.size() > 0 && gap_exp > 0) check(cyc - stamp, gap_exp);
         stamp = cyc;
         got.push_back(tx.code);
      end
      if (second_phase_done === 1'b1) begin
         done_seen++;
         check(tx.valid, 1'b1);
      end
   end

   // ****************************************************************
   // Shared sequence: phase 1 walk, optional entry pulses, phase 2
   // ****************************************************************
   // Skipped for zero pulses so run is never driven twice in one step
   task automatic pulse_for(input int n);
      if (n > 0) begin
         run <= 1'b1;
         repeat (n * 4) @(negedge sys_clk);
         run <= 1'b0;
      end
   endtask

   task automatic run_case(input logic len10, input logic syn, input int pre, input int npul,
                           input logic lock, input logic want_prog);
      logic [9:0] exp[$];
      logic [3:0] nb, nv;
      int         i, f, h, r, k;
      @(negedge sys_clk);
      rst <= 1'b1;
      cfg <= {len10, syn};
      user_lock <= lock;
      gap <= 8'h04;
      gap_exp = 0;
      repeat (2) @(negedge sys_clk);
      rst <= 1'b0;
      got.delete();
      done_seen = 0;
      for (i = 0; i < 32; i++) begin
         nib_wr_en <= 1'b1;
         nib_wr_addr <= 5'(i);
         nib_wr_data <= nibv(i);
         @(negedge sys_clk);
      end
      nib_wr_en <= 1'b0;
      check(self_check_en, 1'b1);
      for (i = 0; i < 100 && offset_cancel_one !== 1'b1; i++) @(negedge sys_clk);
      check({offset_cancel_one, offset_cancel_two}, 2'b10);
      pulse_for(pre);
      for (i = 0; i < 100 && offset_cancel_one !== 1'b0; i++) @(negedge sys_clk);
      check({offset_cancel_one, offset_cancel_two}, 2'b00);
      pulse_for(npul);
      for (i = 0; i < 300 && offset_cancel_two !== 1'b1; i++) @(negedge sys_clk);
      check({offset_cancel_two, prog_mode, second_phase_start}, 3'b100);
      for (i = 0; i < 100 && !(prog_mode === 1'b1 || second_phase_start === 1'b1); i++)
         @(negedge sys_clk);
      check(prog_mode, want_prog);
      check(second_phase_start, !want_prog);
      check(got.size(), 0);
      if (want_prog) begin
         repeat (300) @(negedge sys_clk);
         check({prog_mode, normal_mode, 8'(got.size())}, 10'h200);
         return;
      end
      check(self_check_en, 1'b1);
      cfg <= ~cfg;
      gap <= 8'h06;
      run <= syn;
      gap_exp = syn ? 6 : FRAME;
      for (i = 0; i < 6000 && normal_mode !== 1'b1; i++) @(negedge sys_clk);
      run <= 1'b0;
      repeat (20) @(negedge sys_clk);
      check(normal_mode, 1'b1);
      check({second_phase_start, self_check_en}, 2'b00);
      check(done_seen, 1);
      k = syn ? 4 : 8;
      for (f = 0; f < (len10 ? 32 : 9); f++) begin
         for (h = 0; h < (len10 ? 1 : 2); h++) begin
            nv = nibv(f);
            nb = len10 ? nv : (h == 0 ? {2'b00, nv[3:2]} : {2'b00, nv[1:0]});
            for (r = 0; r < k; r++) begin
               exp.push_back(len10 ? 10'h20f - f[3:0] : {2'b00, 8'h83 - {f[0], h[0]}});
               exp.push_back(len10 ? 10'h21f - nb : {2'b00, 8'h87 - nb});
            end
         end
      end
      check(got.size(), (len10 ? 2 : 4) * k * (len10 ? 32 : 9));
      for (i = 0; i < exp.size() && i < got.size(); i++)
         check(got[i], exp[i]);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_reset;
      check({tx.valid, self_check_en, offset_cancel_one, offset_cancel_two}, 4'b0100);
      check({prog_mode, second_phase_start, second_phase_done, normal_mode}, 4'h0);
      $display("test reset done");
   endtask

   task automatic test_async10;
      run_case(1'b1, 1'b0, 0, 0, 1'b0, 1'b0);
      $display("test async 10-bit done");
   endtask

   task automatic test_sync10;
      run_case(1'b1, 1'b1, 0, 0, 1'b0, 1'b0);
      $display("test sync 10-bit done");
   endtask

   task automatic test_async8;
      run_case(1'b0, 1'b0, 0, 0, 1'b0, 1'b0);
      $display("test async 8-bit done");
   endtask

   task automatic test_sync8;
      run_case(1'b0, 1'b1, 0, 0, 1'b0, 1'b0);
      $display("test sync 8-bit done");
   endtask

   task automatic test_entry;
      run_case(1'b1, 1'b0, 0, 4, 1'b0, 1'b1);
      $display("test entry done");
   endtask

   task automatic test_locked;
      run_case(1'b0, 1'b0, 0, 4, 1'b1, 1'b0);
      $display("test locked done");
   endtask

   task automatic test_stray;
      run_case(1'b1, 1'b0, 1, 3, 1'b0, 1'b0);
      $display("test stray pulse done");
   endtask

   initial begin
      repeat (16) @(negedge sys_clk);
      test_reset();
      test_entry();
      test_locked();
      test_stray();
      test_async10();
      test_sync10();
      test_async8();
      test_sync8();
      summarize();
   end
endmodule
